//--- sep_pkg.sv
// Constants shared by the serial memory port front end.
// Assumes a single clock system side and a master-driven serial clock.
package sep_pkg;
   // -----------------------------------------------------------------
   // Geometry
   // -----------------------------------------------------------------
   localparam int BYTE_W     = 8;
   localparam int MEM_ADDR_W = 13;
   localparam int MEM_DEPTH  = 8192;
   localparam int ID_ADDR_W  = 5;
   localparam int ID_DEPTH   = 32;
   localparam int FIFO_DEPTH = 8;
   localparam int KIND_W     = 2;
   localparam int RX_W       = BYTE_W + KIND_W;

   // -----------------------------------------------------------------
   // Serial framing
   // -----------------------------------------------------------------
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [2:0] BIT_LAST  = 3'h7;
   localparam int         MSB       = BYTE_W - 1;

   typedef enum logic [1:0] {
      SEP_KIND_INSTR   = 2'h0,
      SEP_KIND_ADDR_HI = 2'h1,
      SEP_KIND_ADDR_LO = 2'h2,
      SEP_KIND_DATA    = 2'h3
   } sep_kind_t;

   typedef enum logic [1:0] {
      SEP_PWR_STANDBY = 2'h0,
      SEP_PWR_BUSY    = 2'h1,
      SEP_PWR_ACTIVE  = 2'h2
   } sep_pwr_t;
endpackage : sep_pkg

//--- sep_top.sv
// Serial slave front end of a byte-wide serial memory, with its FIFO.
// Assumes SCK, CS_N, SDI and HOLD_N come from an external bus master and
// that CS_N stays low at least four SYS_CLK cycles after the last SCK rise.
`timescale 1ns/1ns

// ---------------------------------------------------------------------
// Receive FIFO
// ---------------------------------------------------------------------
module sep_fifo #(
   parameter int W     = 10,
   parameter int DEPTH = 8
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : sep_fifo

// ---------------------------------------------------------------------
// Port top
// ---------------------------------------------------------------------
// Behaviour
// R1: Output bits change on SCK falling edge
// R2: Input sampled on SCK rising while selected
// R3: Incoming bytes tagged instruction, address, data
// R4: Deselected means output released
// R5: Deselected enters standby unless write running
// R6: Low select gives active mode
// R7: Ignore traffic until first select falling edge
// R8: Pause freezes bit position while selected
// R9: Paused: output released, clock and data ignored
// R10: Pause only accepted while selected
// R11: Array of 8192 bytes, 13-bit address
// R12: 32-byte identification page with permanent lock; here RESET clears lock_q
// R13: Only select and pause steer the port
// R14: All bytes travel most significant bit first
// R15: Pause starts only with clock low
// R16: Pause ends only with clock low
// R17: Deselect during pause resets protocol state
// R18: Deselect clears bit and byte counters
module sep_top (
   input  wire logic                         SYS_CLK,
   input  wire logic                         RESET,
   input  wire logic                         SCK,
   input  wire logic                         CS_N,
   input  wire logic                         SDI,
   input  wire logic                         HOLD_N,
   output logic                              SDO_OUT,
   output logic                              SDO_OE,
   input  wire logic [sep_pkg::BYTE_W-1:0]   TX_BYTE,
   input  wire logic                         TX_LOAD,
   input  wire logic                         TX_ENABLE,
   input  wire logic                         WRITE_BUSY,
   output logic                              RX_VALID,
   input  wire logic                         RX_READY,
   output logic [sep_pkg::BYTE_W-1:0]        RX_DATA,
   output logic [sep_pkg::KIND_W-1:0]        RX_KIND,
   output logic                              RX_OVERRUN,
   output logic                              ACTIVE,
   output logic                              STANDBY,
   output logic                              PAUSED,
   input  wire logic [sep_pkg::MEM_ADDR_W-1:0] MEM_ADDR,
   input  wire logic                         MEM_ID_SEL,
   input  wire logic                         MEM_WE,
   input  wire logic [sep_pkg::BYTE_W-1:0]   MEM_WDATA,
   output logic [sep_pkg::BYTE_W-1:0]        MEM_RDATA,
   input  wire logic                         ID_LOCK,
   output logic                              ID_LOCKED
);
   // -----------------------------------------------------------------
   // Link domain: receive shifter, cleared while deselected
   // -----------------------------------------------------------------
   logic [2:0]                   bit_q;
   logic [sep_pkg::MSB-1:0]      rx_sh_q;
   logic [sep_pkg::BYTE_W-1:0]   byte_q;
   logic [sep_pkg::KIND_W-1:0]   kind_q;
   logic [sep_pkg::KIND_W-1:0]   idx_q;
   logic                         tog_q;
   logic [sep_pkg::MSB-1:0]      tx_sh_q;
   logic                         sdo_q;
   logic [sep_pkg::BYTE_W-1:0]   tx_word_q;

   always_ff @(posedge SCK or posedge CS_N) begin
      if (CS_N) begin
         bit_q   <= sep_pkg::BIT_FIRST; // R17 R18
         rx_sh_q <= '0;
         idx_q   <= sep_pkg::SEP_KIND_INSTR;
      end else if (HOLD_N) begin // R8 R9 R15 R16
         rx_sh_q <= {rx_sh_q[sep_pkg::MSB-2:0], SDI}; // R2 R14
         bit_q   <= bit_q + 3'h1;
         if (bit_q == sep_pkg::BIT_LAST &&
             idx_q != sep_pkg::SEP_KIND_DATA) begin
            idx_q <= idx_q + 2'h1; // R3
         end
      end
   end

   always_ff @(posedge SCK or posedge CS_N) begin
      if (CS_N) begin
         byte_q <= '0;
         kind_q <= sep_pkg::SEP_KIND_INSTR;
         tog_q  <= 1'b0;
      end else if (HOLD_N && bit_q == sep_pkg::BIT_LAST) begin
         byte_q <= {rx_sh_q, SDI}; // R14
         kind_q <= idx_q; // R3
         tog_q  <= ~tog_q;
      end
   end

   // -----------------------------------------------------------------
   // Link domain: transmit shifter on the falling edge
   // -----------------------------------------------------------------
   always_ff @(negedge SCK or posedge CS_N) begin
      if (CS_N) begin
         tx_sh_q <= '0;
         sdo_q   <= 1'b0;
      end else if (HOLD_N) begin // R9
         if (bit_q == sep_pkg::BIT_FIRST) begin
            sdo_q   <= tx_word_q[sep_pkg::MSB]; // R1 R14
            tx_sh_q <= tx_word_q[sep_pkg::MSB-1:0];
         end else begin
            sdo_q   <= tx_sh_q[sep_pkg::MSB-1]; // R1 R14
            tx_sh_q <= {tx_sh_q[sep_pkg::MSB-2:0], 1'b0};
         end
      end
   end

   assign SDO_OUT = sdo_q;

   // -----------------------------------------------------------------
   // System domain: synchronisers
   // -----------------------------------------------------------------
   logic cs_m;
   logic cs_s;
   logic hold_m;
   logic hold_s;
   logic sck_m;
   logic sck_s;
   logic tog_m;
   logic tog_s;

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         // Reset never counts as a high select, so it cannot arm
         cs_m   <= 1'b0;
         cs_s   <= 1'b0;
         hold_m <= 1'b1;
         hold_s <= 1'b1;
         sck_m  <= 1'b0;
         sck_s  <= 1'b0;
         tog_m  <= 1'b0;
         tog_s  <= 1'b0;
      end else begin
         cs_m   <= CS_N;
         cs_s   <= cs_m;
         hold_m <= HOLD_N;
         hold_s <= hold_m;
         sck_m  <= SCK;
         sck_s  <= sck_m;
         tog_m  <= tog_q;
         tog_s  <= tog_m;
      end
   end

   // -----------------------------------------------------------------
   // System domain: selection, pause and power mode
   // -----------------------------------------------------------------
   logic              armed_q;
   logic              sel;
   logic              hold_q;
   sep_pkg::sep_pwr_t pwr_d;
   sep_pkg::sep_pwr_t pwr_q;
   logic              act_q;
   logic              stby_q;
   logic              oe_q;

   assign sel = ~cs_s & armed_q; // R6 R7 R13

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         armed_q <= 1'b0;
      end else if (cs_s) begin
         armed_q <= 1'b1; // R7
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         hold_q <= 1'b0;
      end else if (!sel) begin
         hold_q <= 1'b0; // R10 R17
      end else if (!sck_s) begin
         hold_q <= ~hold_s; // R15 R16
      end
   end

   always_comb begin
      case ({sel, WRITE_BUSY})
         2'h2, 2'h3: pwr_d = sep_pkg::SEP_PWR_ACTIVE; // R6
         2'h1:       pwr_d = sep_pkg::SEP_PWR_BUSY; // R5
         default:    pwr_d = sep_pkg::SEP_PWR_STANDBY; // R5
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         pwr_q  <= sep_pkg::SEP_PWR_STANDBY;
         act_q  <= 1'b0;
         stby_q <= 1'b1;
      end else begin
         pwr_q  <= pwr_d;
         act_q  <= (pwr_d == sep_pkg::SEP_PWR_ACTIVE);
         stby_q <= (pwr_d == sep_pkg::SEP_PWR_STANDBY);
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= sel & ~hold_q & TX_ENABLE; // R4 R9
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         tx_word_q <= '0;
      end else if (TX_LOAD) begin
         tx_word_q <= TX_BYTE;
      end
   end

   assign ACTIVE  = act_q;
   assign STANDBY = stby_q;
   assign PAUSED  = hold_q;
   assign SDO_OE  = oe_q;

   // -----------------------------------------------------------------
   // System domain: byte capture into the FIFO
   // -----------------------------------------------------------------
   logic                      ref_q;
   logic                      ev;
   logic                      ev_ok;
   logic                      pend_q;
   logic [sep_pkg::RX_W-1:0]  pend_d_q;
   logic                      ovr_q;
   logic                      f_ir;
   logic                      f_ov;
   logic [sep_pkg::RX_W-1:0]  f_od;
   logic                      pop;
   logic                      rx_v_q;
   logic [sep_pkg::RX_W-1:0]  rx_d_q;

   assign ev    = tog_s ^ ref_q;
   // A fall of the toggle seen while deselected is the link-side clear
   assign ev_ok = ev & armed_q & ~(cs_s & ~tog_s); // R7 R18

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         ref_q    <= 1'b0;
         pend_q   <= 1'b0;
         pend_d_q <= '0;
         ovr_q    <= 1'b0;
      end else begin
         ovr_q <= 1'b0;
         if (ev) begin
            ref_q <= tog_s;
         end
         if (ev_ok) begin
            pend_q   <= 1'b1;
            pend_d_q <= {kind_q, byte_q};
            ovr_q    <= pend_q & ~f_ir;
         end else if (f_ir) begin
            pend_q <= 1'b0;
         end
      end
   end

   sep_fifo #(
      .W     (sep_pkg::RX_W),
      .DEPTH (sep_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (SYS_CLK),
      .rst       (RESET),
      .in_valid  (pend_q),
      .in_ready  (f_ir),
      .in_data   (pend_d_q),
      .out_valid (f_ov),
      .out_ready (pop),
      .out_data  (f_od)
   );

   assign pop = f_ov & (~rx_v_q | RX_READY);

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         rx_v_q <= 1'b0;
         rx_d_q <= '0;
      end else if (pop) begin
         rx_v_q <= 1'b1;
         rx_d_q <= f_od;
      end else if (RX_READY) begin
         rx_v_q <= 1'b0;
      end
   end

   assign RX_VALID   = rx_v_q;
   assign RX_DATA    = rx_d_q[sep_pkg::BYTE_W-1:0];
   assign RX_KIND    = rx_d_q[sep_pkg::RX_W-1:sep_pkg::BYTE_W];
   assign RX_OVERRUN = ovr_q;

   // -----------------------------------------------------------------
   // Memory array and identification page
   // -----------------------------------------------------------------
   logic [sep_pkg::BYTE_W-1:0] arr_q [sep_pkg::MEM_DEPTH]; // R11
   logic [sep_pkg::BYTE_W-1:0] id_q  [sep_pkg::ID_DEPTH]; // R12
   logic [sep_pkg::BYTE_W-1:0] rd_q;
   logic                       lock_q;
   logic [sep_pkg::ID_ADDR_W-1:0] id_a;

   assign id_a = MEM_ADDR[sep_pkg::ID_ADDR_W-1:0];

   always_ff @(posedge SYS_CLK) begin
      if (MEM_WE && !MEM_ID_SEL) begin
         arr_q[MEM_ADDR] <= MEM_WDATA; // R11
      end
      if (MEM_WE && MEM_ID_SEL && !lock_q) begin
         id_q[id_a] <= MEM_WDATA; // R12
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         rd_q <= '0;
      end else begin
         rd_q <= MEM_ID_SEL ? id_q[id_a] : arr_q[MEM_ADDR];
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         lock_q <= 1'b0;
      end else if (ID_LOCK) begin
         lock_q <= 1'b1; // R12
      end
   end

   assign MEM_RDATA = rd_q;
   assign ID_LOCKED = lock_q;
endmodule : sep_top

//--- sep_master_model.sv
// Serial bus master model that drives the port pins of the memory.
// Assumes clock idle low between frames; the bench calls its tasks.
`timescale 1ns/1ns
module sep_master_model (
   output logic      sck,
   output logic      cs_n,
   output logic      sdi,
   output logic      hold_n,
   input  wire logic sdo,
   input  wire logic sdo_oe
);
   logic [7:0] rx_q;
   initial begin
      sck    = 1'h0;
      cs_n   = 1'h0;
      sdi    = 1'h0;
      hold_n = 1'h1;
      rx_q   = 8'h00;
   end
   // Sends n bits from the top of d and captures the line at each rise
   task automatic shift(input logic [7:0] d, input int n);
      for (int i = 0; i < n; i++) begin
         sdi = d[7-i];
         #62 sck = 1'h1;
         rx_q = {rx_q[6:0], sdo_oe ? sdo : ~rx_q[0]};
         #63 sck = 1'h0;
      end
      sdi = ~sdi;
   endtask : shift
   task automatic sel(input logic lvl);
      cs_n = lvl;
      #64;
   endtask : sel
   task automatic hold(input logic lvl);
      hold_n = lvl;
      #64;
   endtask : hold
endmodule : sep_master_model

//--- sep_chk_sva.sv
// Concurrent checks on the serial port top, bound into sep_top.
// Assumes one SYS_CLK domain with synchronous active-high RESET.
`timescale 1ns/1ns
module sep_sva_chk (
   input wire logic                       SYS_CLK,
   input wire logic                       RESET,
   input wire logic                       SCK,
   input wire logic                       CS_N,
   input wire logic                       HOLD_N,
   input wire logic                       SDO_OUT,
   input wire logic                       SDO_OE,
   input wire logic                       WRITE_BUSY,
   input wire logic                       RX_VALID,
   input wire logic                       RX_READY,
   input wire logic [sep_pkg::BYTE_W-1:0] RX_DATA,
   input wire logic [sep_pkg::KIND_W-1:0] RX_KIND,
   input wire logic                       RX_OVERRUN,
   input wire logic                       ACTIVE,
   input wire logic                       STANDBY,
   input wire logic                       PAUSED
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   a_out_fall_edge: assert property (
      $changed(SDO_OUT) && !CS_N |-> !SCK)
      else $error("serial output moved while clock high");
   a_desel_out_off: assert property (
      CS_N [*6] |-> !SDO_OE) else $error("output driven while deselected");
   a_standby_idle: assert property (
      (CS_N && !WRITE_BUSY) [*6] |-> STANDBY) else $error("no standby");
   a_busy_no_stby: assert property (
      WRITE_BUSY [*3] |-> !STANDBY) else $error("standby during write");
   a_desel_inactive: assert property (
      CS_N [*6] |-> !ACTIVE) else $error("active while deselected");
   a_active_awake: assert property (
      ACTIVE |-> !STANDBY) else $error("active and standby together");
   a_pause_out_off: assert property (
      PAUSED [*2] |-> !SDO_OE) else $error("output driven while paused");
   a_pause_need_sel: assert property (
      CS_N [*6] |-> !PAUSED) else $error("paused while deselected");
   a_pause_start: assert property (
      $rose(PAUSED) |-> !HOLD_N && !SCK) else $error("bad pause start");
   a_pause_end: assert property (
      $fell(PAUSED) && !CS_N |-> HOLD_N && !SCK)
      else $error("bad pause end");
   a_rx_stands: assert property (
      RX_VALID && !RX_READY |=> RX_OVERRUN ||
      (RX_VALID && $stable(RX_DATA) && $stable(RX_KIND)))
      else $error("received byte dropped before taken");
endmodule : sep_sva_chk
bind sep_top sep_sva_chk u_chk (.SYS_CLK, .RESET, .SCK, .CS_N, .HOLD_N,
   .SDO_OUT, .SDO_OE, .WRITE_BUSY, .RX_VALID, .RX_READY, .RX_DATA,
   .RX_KIND, .RX_OVERRUN, .ACTIVE, .STANDBY, .PAUSED);

//--- tb_top.sv
// Self-checking bench for the serial port top and its receive FIFO.
// Assumes sep_master_model drives the link pins.
`timescale 1ns/1ns
module tb_top;
   logic        SYS_CLK, RESET, TX_LOAD, TX_ENABLE, WRITE_BUSY, RX_READY;
   logic        SCK, CS_N, SDI, HOLD_N, SDO_OUT, SDO_OE;
   logic [7:0]  TX_BYTE, MEM_WDATA;
   logic        RX_VALID, RX_OVERRUN, ACTIVE, STANDBY, PAUSED, ID_LOCKED;
   logic [7:0]  RX_DATA, MEM_RDATA;
   logic [1:0]  RX_KIND;
   logic [12:0] MEM_ADDR;
   logic        MEM_ID_SEL, MEM_WE, ID_LOCK;
   logic        ovr_seen = 1'h0;
   int          num_errors = 0;
   int          n_compared = 0;

   sep_top DUT (.SYS_CLK, .RESET, .SCK, .CS_N, .SDI, .HOLD_N, .SDO_OUT,
      .SDO_OE, .TX_BYTE, .TX_LOAD, .TX_ENABLE, .WRITE_BUSY, .RX_VALID,
      .RX_READY, .RX_DATA, .RX_KIND, .RX_OVERRUN, .ACTIVE, .STANDBY,
      .PAUSED, .MEM_ADDR, .MEM_ID_SEL, .MEM_WE, .MEM_WDATA, .MEM_RDATA,
      .ID_LOCK, .ID_LOCKED);
   sep_master_model M (.sck(SCK), .cs_n(CS_N), .sdi(SDI), .hold_n(HOLD_N),
      .sdo(SDO_OUT), .sdo_oe(SDO_OE));

   always #4 SYS_CLK = ~SYS_CLK;
   always @(posedge SYS_CLK) if (RX_OVERRUN === 1'h1) ovr_seen <= 1'h1;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, exp, input string nm);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge SYS_CLK);
      #1;
   endtask : cyc
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done
   function automatic logic [7:0] pat(input int i);
      return 8'h5a + 8'(i) * 8'h25;
   endfunction : pat
   // Waits for a received byte, judges it and takes it
   task automatic take(input logic [7:0] d, input logic [1:0] k);
      int i;
      cyc(1);
      for (i = 0; i < 300 && RX_VALID !== 1'h1; i++) cyc(1);
      if (i == 300) begin
         chk(8'(RX_VALID), 8'h01, "rx valid");
         test_done();
      end
      chk(RX_DATA, d, "rx data");
      chk(8'(RX_KIND), 8'(k), "rx kind");
      RX_READY = 1'h1;
      cyc(1);
      RX_READY = 1'h0;
   endtask : take
   task automatic rd(input logic [12:0] a, input logic s, input logic [7:0] e);
      MEM_ADDR = a;
      MEM_ID_SEL = s;
      cyc(1);
      chk(MEM_RDATA, e, "mem rdata");
   endtask : rd
   task automatic wr(input logic [12:0] a, input logic s, input logic [7:0] d);
      MEM_ADDR = a;
      MEM_ID_SEL = s;
      MEM_WDATA = d;
      MEM_WE = 1'h1;
      cyc(1);
      MEM_WE = 1'h0;
      cyc(1);
   endtask : wr

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_arm;
      M.shift(8'h5a, 8);
      cyc(40);
      chk(8'(RX_VALID), 8'h00, "unarmed rx");
      chk(8'(ACTIVE), 8'h00, "unarmed active");
      M.sel(1'h1);
      $display("test arm done");
   endtask : t_arm
   task automatic t_frame;
      cyc(1);
      TX_BYTE = 8'hc3;
      TX_LOAD = 1'h1;
      cyc(1);
      TX_LOAD = 1'h0;
      TX_ENABLE = 1'h1;
      M.sel(1'h0);
      for (int i = 0; i < 11; i++) begin
         M.shift(pat(i), 8);
         if (i == 1) chk(M.rx_q, 8'hc3, "sdo byte");
      end
      chk(8'(SDO_OE), 8'h01, "oe selected");
      chk(8'(ACTIVE), 8'h01, "active");
      M.sel(1'h1);
      chk(8'(SDO_OE), 8'h00, "oe deselected");
      for (int i = 0; i < 8; i++) take(pat(i), i > 3 ? 2'h3 : 2'(i));
      chk(8'(ovr_seen), 8'h01, "overrun");
      cyc(1);
      RX_READY = 1'h1;
      cyc(4);
      RX_READY = 1'h0;
      chk(8'(RX_VALID), 8'h00, "fifo empty");
      $display("test frame done");
   endtask : t_frame
   task automatic t_hold;
      M.sel(1'h0);
      M.shift(8'h96, 4);
      M.hold(1'h0);
      chk(8'(PAUSED), 8'h01, "paused");
      chk(8'(SDO_OE), 8'h00, "oe paused");
      M.shift(8'hff, 3);
      M.hold(1'h1);
      chk(8'(PAUSED), 8'h00, "resumed");
      M.shift(8'h60, 4);
      M.sel(1'h1);
      take(8'h96, 2'h0);
      $display("test hold done");
   endtask : t_hold
   task automatic t_desel;
      M.hold(1'h0);
      chk(8'(PAUSED), 8'h00, "pause deselected");
      M.hold(1'h1);
      cyc(1);
      WRITE_BUSY = 1'h1;
      cyc(4);
      chk(8'(STANDBY), 8'h00, "standby busy");
      WRITE_BUSY = 1'h0;
      cyc(4);
      chk(8'(STANDBY), 8'h01, "standby idle");
      M.sel(1'h0);
      M.shift(8'he1, 3);
      M.hold(1'h0);
      M.sel(1'h1);
      M.hold(1'h1);
      M.sel(1'h0);
      M.shift(8'h3c, 8);
      M.sel(1'h1);
      take(8'h3c, 2'h0);
      cyc(8);
      chk(8'(RX_VALID), 8'h00, "no partial");
      $display("test deselect done");
   endtask : t_desel
   task automatic t_mem;
      wr(13'h0fff, 1'h0, 8'h11);
      wr(13'h1fff, 1'h0, 8'ha5);
      rd(13'h1fff, 1'h0, 8'ha5);
      rd(13'h0fff, 1'h0, 8'h11);
      wr(13'h001f, 1'h1, 8'h3c);
      ID_LOCK = 1'h1;
      cyc(1);
      ID_LOCK = 1'h0;
      wr(13'h001f, 1'h1, 8'h00);
      rd(13'h001f, 1'h1, 8'h3c);
      chk(8'(ID_LOCKED), 8'h01, "id locked");
      $display("test memory done");
   endtask : t_mem

   initial begin
      RESET = 1'h1;
      {SYS_CLK, TX_LOAD, TX_ENABLE, WRITE_BUSY, RX_READY, MEM_ID_SEL,
         MEM_WE, ID_LOCK, TX_BYTE, MEM_WDATA, MEM_ADDR} = '0;
      cyc(2);
      RESET = 1'h0;
      cyc(4);
      t_arm();
      t_frame();
      t_hold();
      t_desel();
      t_mem();
      test_done();
   end
endmodule : tb_top
